// ===== common/cmg_pkg.sv
// Purpose: constants and types of the clock mode and gating unit
// Assumes: registers sit one per 32-bit apb word
// Notes:   byte address is four times the register index
package cmg_pkg;

   // source rates; every derived rate follows from these
   localparam int unsigned OSC_HZ = 12_000_000;
   localparam int unsigned PLL_HZ = 60_000_000;

   // register indices and byte addresses
   localparam logic [7:0]  IDX_MODE = 8'h5b;
   localparam logic [7:0]  IDX_LS   = 8'h5c;
   localparam logic [7:0]  IDX_HS   = 8'h5d;
   localparam logic [11:0] ADR_MODE = {2'h0, IDX_MODE, 2'h0};
   localparam logic [11:0] ADR_LS   = {2'h0, IDX_LS, 2'h0};
   localparam logic [11:0] ADR_HS   = {2'h0, IDX_HS, 2'h0};

   // clock_mode_control fields
   localparam int DIV_BIT          = 0;
   localparam int RUN_BIT          = 1;
   localparam int LOCK_BIT         = 2;
   localparam int HALT_REG_OFF_BIT = 7;

   // low_speed_clock_gates fields
   localparam int DBG_BIT      = 0;
   localparam int TIMER_BIT    = 1;
   localparam int WATCHDOG_BIT = 2;
   localparam int SPI_BIT      = 3;
   localparam int TIMEBASE_BIT = 4;

   // high_speed_clock_gates fields
   localparam int SI_BIT         = 0;
   localparam int RS_ENCODER_BIT = 1;
   localparam int RS_DECODER_BIT = 2;
   localparam int USB_BIT        = 3;

   // values after reset
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] LS_RST   = 8'h00;
   localparam logic [7:0] HS_RST   = 8'h00;

   // cycles all derived clocks stay stopped around a switch
   localparam logic [2:0] HOLD_CYCLES = 3'h4;
   localparam logic [2:0] HOLD_MID    = 3'h2;

   typedef enum logic [2:0] {
      st_low,
      st_wait_lock,
      st_switch_up,
      st_full,
      st_switch_down
   } cmg_state_type;

endpackage

// ===== logic/cmg_clock_unit.sv
// Purpose: run mode, cpu divider and clock gate control over apb
// Assumes: clock cells downstream switch and gate on these levels
// Notes:   every output is a flop; apb answers with one wait-free access
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Operation
// R01: sources derive from 12 MHz oscillator
// R02: low power: oscillator source, pll off, no usb
// R03: full power: 60 MHz pll source
// R04: reset to low power; run bit 1
// R05: divider bit 0: /2 or /4
// R06: bit 2 read-only pll lock
// R07: wait for lock on oscillator rates
// R08: unlocked: cpu 6/3, core 6, periph 12
// R09: locked full: cpu 30/15, core 30, periph 60
// R10: halt with bit 7 powers regulator down
// R11: wake from halt clears bit 7
// R12: software sets bit 7 before halt
// R13: mode bits 6:3 reserved, kept zero
// R14: gates for timebase, spi, timer
// R15: bit 2 gates watchdog clock
// R16: hardware watchdog option forces watchdog clock
// R17: debug clock bit sticky until reset
// R18: high speed bit 3 gates usb
// R19: bit 2 gates rs decoder
// R20: bit 1 gates rs encoder
// R21: bit 0 gates storage interface core
// R22: all three registers reset to zero
// R23: switching and gating without runt pulses
module cmg_clock_unit (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_pll_lock,
   input  wire logic        i_hw_watchdog_option,
   input  wire logic        i_halt_entry,
   input  wire logic        i_halt_wake,
   output logic             o_pll_enable,
   output logic             o_src_pll,
   output logic             o_cpu_div4,
   output logic             o_clk_hold,
   output logic             o_regulator_pd,
   output logic             o_timebase_unit_clk_en,
   output logic             o_spi_clk_en,
   output logic             o_watchdog_clk_en,
   output logic             o_timer_clk_en,
   output logic             o_debug_module_clk_en,
   output logic             o_usb_clk_en,
   output logic             o_rs_decoder_clk_en,
   output logic             o_rs_encoder_clk_en,
   output logic             o_storage_interface_clk_en
);
   import cmg_pkg::*;

   cmg_state_type state_ff;
   cmg_state_type nxt_state;

   logic        lock_s1_ff;
   logic        lock_s2_ff;
   logic        hwwd_s1_ff;
   logic        hwwd_s2_ff;
   logic        run_ff;
   logic        div_ff;
   logic        halt_reg_off_ff;
   logic [4:0]  ls_ff;
   logic [3:0]  hs_ff;
   logic [2:0]  hold_cnt_ff;
   logic [2:0]  nxt_hold_cnt;
   logic        src_pll_ff;
   logic        cpu_div4_ff;
   logic        hold_ff;
   logic        pll_en_ff;
   logic        reg_pd_ff;
   logic [4:0]  ls_gate_ff;
   logic [2:0]  hs_gate_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;

   ////////////////////////////////////////////////////////////////////
   // apb decode

   wire        setup_ph   = i_psel & ~i_penable;
   wire        access_ok  = i_psel & i_penable & pready_ff;
   wire        hit_mode   = (i_paddr == ADR_MODE);
   wire        hit_ls     = (i_paddr == ADR_LS);
   wire        hit_hs     = (i_paddr == ADR_HS);
   wire        hit_any    = hit_mode | hit_ls | hit_hs;
   wire        wr_ok      = access_ok & i_pwrite & hit_any;
   wire        wr_mode    = wr_ok & hit_mode;
   wire        wr_ls      = wr_ok & hit_ls;
   wire        wr_hs      = wr_ok & hit_hs;
   wire [7:0]  wd         = i_pwdata[7:0];

   // reserved bits 6:3 are not stored and read as zero
   wire [7:0]  mode_view  = {halt_reg_off_ff, 4'h0, lock_s2_ff,    // R06 R13
                             run_ff, div_ff};
   wire [7:0]  ls_view    = {3'h0, ls_ff};
   wire [7:0]  hs_view    = {4'h0, hs_ff};
   wire [7:0]  rd_byte    = hit_mode ? mode_view :
                            hit_ls   ? ls_view   :
                            hit_hs   ? hs_view   : 8'h00;

   ////////////////////////////////////////////////////////////////////
   // apb answer: data latched in setup, ready during access

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_ff <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= setup_ph & ~hit_any;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // synchronisers; lock and option come from outside this clock

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lock_s1_ff <= 1'b0;
         lock_s2_ff <= 1'b0;
         hwwd_s1_ff <= 1'b0;
         hwwd_s2_ff <= 1'b0;
      end else begin
         lock_s1_ff <= i_pll_lock;
         lock_s2_ff <= lock_s1_ff;
         hwwd_s1_ff <= i_hw_watchdog_option;
         hwwd_s2_ff <= hwwd_s1_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // software registers

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         run_ff <= MODE_RST[RUN_BIT];                        // R04 R22
         div_ff <= MODE_RST[DIV_BIT];                        // R22
      end else if (wr_mode) begin
         run_ff <= wd[RUN_BIT];                              // R04
         div_ff <= wd[DIV_BIT];                              // R05
      end
   end

   // a write setting the bit beats a wake in the same cycle
   wire nxt_halt_reg_off = wr_mode ? wd[HALT_REG_OFF_BIT] :
                           (i_halt_wake ? 1'b0 : halt_reg_off_ff);  // R11

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         halt_reg_off_ff <= MODE_RST[HALT_REG_OFF_BIT];      // R22
      end else begin
         halt_reg_off_ff <= nxt_halt_reg_off;
      end
   end

   // debug enable can only be raised by software
   wire [4:0] nxt_ls = {wd[TIMEBASE_BIT:TIMER_BIT],
                        ls_ff[DBG_BIT] | wd[DBG_BIT]};       // R17

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ls_ff <= LS_RST[4:0];                               // R22
      end else if (wr_ls) begin
         ls_ff <= nxt_ls;                                    // R14 R15
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hs_ff <= HS_RST[3:0];                               // R22
      end else if (wr_hs) begin
         hs_ff <= wd[USB_BIT:SI_BIT];                        // R18 R19 R20 R21
      end
   end

   ////////////////////////////////////////////////////////////////////
   // run mode sequencing

   wire idle_hold  = (hold_cnt_ff == 3'h0);
   wire last_hold  = (hold_cnt_ff == 3'h1);
   wire at_mid     = (hold_cnt_ff == HOLD_MID);
   wire go_up      = (state_ff == st_wait_lock) & run_ff & lock_s2_ff;
   wire go_down    = (state_ff == st_full) & (~run_ff | ~lock_s2_ff);
   wire div_change = idle_hold & (div_ff != cpu_div4_ff);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         st_low: begin
            if (run_ff) begin
               nxt_state = st_wait_lock;                     // R04 R07
            end
         end
         st_wait_lock: begin
            if (!run_ff) begin
               nxt_state = st_low;
            end else if (lock_s2_ff) begin
               nxt_state = st_switch_up;                     // R07
            end
         end
         st_switch_up: begin
            if (last_hold) begin
               nxt_state = st_full;                          // R03
            end
         end
         st_full: begin
            if (!run_ff || !lock_s2_ff) begin
               nxt_state = st_switch_down;
            end
         end
         st_switch_down: begin
            if (last_hold) begin
               nxt_state = run_ff ? st_wait_lock : st_low;   // R02
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= st_low;                                 // R04
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hold window: clocks stop, source or divider flips mid-window

   always_comb begin
      nxt_hold_cnt = hold_cnt_ff;
      if (go_up || go_down || div_change) begin
         nxt_hold_cnt = HOLD_CYCLES;                         // R23
      end else if (!idle_hold) begin
         nxt_hold_cnt = hold_cnt_ff - 3'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hold_cnt_ff <= 3'h0;
      end else begin
         hold_cnt_ff <= nxt_hold_cnt;
      end
   end

   // source changes only while every derived clock is stopped
   wire nxt_src_pll =
      (at_mid & (state_ff == st_switch_up))   ? 1'b1 :       // R03 R23
      (at_mid & (state_ff == st_switch_down)) ? 1'b0 :       // R02 R23
      src_pll_ff;

   // divider latched mid-window; later edits start a fresh window
   wire nxt_cpu_div4 = at_mid ? div_ff : cpu_div4_ff;        // R05 R23
   wire nxt_hold     = (nxt_hold_cnt != 3'h0);
   wire nxt_pll_en   = (nxt_state != st_low);                // R02

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src_pll_ff  <= 1'b0;                                // R01 R08
         cpu_div4_ff <= 1'b0;
         hold_ff     <= 1'b0;
         pll_en_ff   <= 1'b0;
      end else begin
         src_pll_ff  <= nxt_src_pll;                         // R08 R09
         cpu_div4_ff <= nxt_cpu_div4;
         hold_ff     <= nxt_hold;
         pll_en_ff   <= nxt_pll_en;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // regulator power-down across halt

   // entry beats a wake arriving in the same cycle
   wire nxt_reg_pd = (i_halt_entry & halt_reg_off_ff) ? 1'b1 :  // R10 R12
                     (i_halt_wake ? 1'b0 : reg_pd_ff);

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         reg_pd_ff <= 1'b0;
      end else begin
         reg_pd_ff <= nxt_reg_pd;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock gates; all low during a hold window

   wire [4:0] ls_want = ls_ff | ({4'h0, hwwd_s2_ff} << WATCHDOG_BIT);  // R16
   // usb gate sits apart below: it also needs the pll source

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_ls
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               ls_gate_ff[g] <= 1'b0;                        // R22
            end else begin
               ls_gate_ff[g] <= ls_want[g] & ~nxt_hold;      // R14 R15 R23
            end
         end
      end
      for (g = 0; g < 3; g++) begin : g_hs
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               hs_gate_ff[g] <= 1'b0;                        // R22
            end else begin
               hs_gate_ff[g] <= hs_ff[g] & ~nxt_hold;        // R19 R20 R21 R23
            end
         end
      end
   endgenerate

   // usb only runs from the pll, never from the oscillator
   logic usb_gate_ff;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         usb_gate_ff <= 1'b0;
      end else begin
         usb_gate_ff <= hs_ff[USB_BIT] & nxt_src_pll & ~nxt_hold;  // R02 R18
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign o_prdata                   = prdata_ff;
   assign o_pready                   = pready_ff;
   assign o_pslverr                  = pslverr_ff;
   assign o_pll_enable               = pll_en_ff;
   assign o_src_pll                  = src_pll_ff;
   assign o_cpu_div4                 = cpu_div4_ff;
   assign o_clk_hold                 = hold_ff;
   assign o_regulator_pd             = reg_pd_ff;
   assign o_timebase_unit_clk_en     = ls_gate_ff[TIMEBASE_BIT];
   assign o_spi_clk_en               = ls_gate_ff[SPI_BIT];
   assign o_watchdog_clk_en          = ls_gate_ff[WATCHDOG_BIT];
   assign o_timer_clk_en             = ls_gate_ff[TIMER_BIT];
   assign o_debug_module_clk_en      = ls_gate_ff[DBG_BIT];
   assign o_usb_clk_en               = usb_gate_ff;
   assign o_rs_decoder_clk_en        = hs_gate_ff[RS_DECODER_BIT];
   assign o_rs_encoder_clk_en        = hs_gate_ff[RS_ENCODER_BIT];
   assign o_storage_interface_clk_en = hs_gate_ff[SI_BIT];

endmodule

`default_nettype wire

// ===== tb/cmg_clock_unit_properties.sv
// Purpose: port-level properties of the clock mode and gating unit
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every cmg_clock_unit instance
`timescale 1ns/1ps
`default_nettype none
module cmg_clock_unit_properties (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_hw_watchdog_option,
   input wire logic        i_halt_entry,
   input wire logic        i_halt_wake,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_pll_enable,
   input wire logic        o_src_pll,
   input wire logic        o_cpu_div4,
   input wire logic        o_clk_hold,
   input wire logic        o_regulator_pd,
   input wire logic        o_timebase_unit_clk_en,
   input wire logic        o_spi_clk_en,
   input wire logic        o_watchdog_clk_en,
   input wire logic        o_timer_clk_en,
   input wire logic        o_debug_module_clk_en,
   input wire logic        o_usb_clk_en,
   input wire logic        o_rs_decoder_clk_en,
   input wire logic        o_rs_encoder_clk_en,
   input wire logic        o_storage_interface_clk_en
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire any_gate = o_timebase_unit_clk_en | o_spi_clk_en | o_watchdog_clk_en | o_timer_clk_en
                 | o_debug_module_clk_en | o_usb_clk_en | o_rs_decoder_clk_en
                 | o_rs_encoder_clk_en | o_storage_interface_clk_en;
////////////////////////////////////////////////////////////////////////
   AST_PREADY: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready in access phase");
   AST_SLVERR: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("error response without ready or with data");
   AST_USB_OSC: assert property (!o_src_pll |-> !o_usb_clk_en)
      else $error("usb clock enabled on oscillator");
   AST_PLL_SRC: assert property (o_src_pll |-> o_pll_enable)
      else $error("tree on pll while pll off");
   AST_HOLD_GATES: assert property (o_clk_hold |-> !any_gate)
      else $error("gate open in hold window");
   AST_HOLD_LEN: assert property ($rose(o_clk_hold) |-> o_clk_hold[*4] ##1 !o_clk_hold)
      else $error("hold window not four cycles");
   AST_SRC_SWITCH: assert property ($changed(o_src_pll) |-> o_clk_hold && $past(o_clk_hold))
      else $error("source switched outside hold");
   AST_DIV_SWITCH: assert property ($changed(o_cpu_div4) |-> o_clk_hold)
      else $error("divider changed outside hold");
   AST_HW_WDG: assert property (i_hw_watchdog_option[*5] ##0 !o_clk_hold[*2] |-> o_watchdog_clk_en)
      else $error("watchdog clock off under hardware option");
   AST_PD_CAUSE: assert property ($rose(o_regulator_pd) |-> $past(i_halt_entry))
      else $error("regulator down without halt");
   AST_PD_WAKE: assert property (i_halt_wake && !i_halt_entry |=> !o_regulator_pd)
      else $error("regulator still down after wake");
   COV_FULL: cover property ($rose(o_src_pll));
   COV_PD: cover property ($rose(o_regulator_pd));
   COV_ERR: cover property (o_pslverr);
endmodule
bind cmg_clock_unit cmg_clock_unit_properties u_props (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
   .i_hw_watchdog_option(i_hw_watchdog_option), .i_halt_entry(i_halt_entry), .i_halt_wake(i_halt_wake),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pll_enable(o_pll_enable),
   .o_src_pll(o_src_pll), .o_cpu_div4(o_cpu_div4), .o_clk_hold(o_clk_hold), .o_regulator_pd(o_regulator_pd),
   .o_timebase_unit_clk_en(o_timebase_unit_clk_en), .o_spi_clk_en(o_spi_clk_en),
   .o_watchdog_clk_en(o_watchdog_clk_en), .o_timer_clk_en(o_timer_clk_en),
   .o_debug_module_clk_en(o_debug_module_clk_en), .o_usb_clk_en(o_usb_clk_en),
   .o_rs_decoder_clk_en(o_rs_decoder_clk_en), .o_rs_encoder_clk_en(o_rs_encoder_clk_en),
   .o_storage_interface_clk_en(o_storage_interface_clk_en));
`default_nettype wire

// ===== tb/cmg_clock_unit_tb_top.sv
// Purpose: register and mode sequence tests of the clock unit
// Assumes: apb answers without a fixed wait, bounded here
// Notes:   waits of 12 cycles cover lock sync plus the hold window
`timescale 1ns/1ps
`default_nettype none
module cmg_clock_unit_tb_top;
   import cmg_pkg::*;
   logic i_clk, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rdv;
   logic i_pll_lock, i_hw_watchdog_option, i_halt_entry, i_halt_wake, errv;
   logic o_pll_enable, o_src_pll, o_cpu_div4, o_clk_hold, o_regulator_pd;
   logic o_timebase_unit_clk_en, o_spi_clk_en, o_watchdog_clk_en, o_timer_clk_en, o_debug_module_clk_en;
   logic o_usb_clk_en, o_rs_decoder_clk_en, o_rs_encoder_clk_en, o_storage_interface_clk_en;
   int num_errors = 0;
   int checks = 0;
   wire logic [4:0] stat = {o_pll_enable, o_src_pll, o_cpu_div4, o_clk_hold, o_regulator_pd};
   wire logic [4:0] lsg = {o_timebase_unit_clk_en, o_spi_clk_en, o_watchdog_clk_en, o_timer_clk_en,
                           o_debug_module_clk_en};
   wire logic [3:0] hsg = {o_usb_clk_en, o_rs_decoder_clk_en, o_rs_encoder_clk_en, o_storage_interface_clk_en};
   cmg_clock_unit u_dut (.*);
   always #50 i_clk = ~i_clk;
////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // bounded wait: a dead slave ends as a mismatch, not a hang
   task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= adr;
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      rdv = o_prdata;
      errv = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [11:0] adr, input logic [31:0] exp);
      apb(1'b0, adr, 32'h0);
      check(name, rdv, exp);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge i_clk);
   endtask
////////////////////////////////////////////////////////////////////////
   initial begin
      {i_clk, i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
      {i_pll_lock, i_hw_watchdog_option, i_halt_entry, i_halt_wake} = '0;
      repeat (8) @(posedge i_clk);
      i_nrst <= 1'b1;
      rd_chk("mode", ADR_MODE, 32'h0);
      rd_chk("low", ADR_LS, 32'h0);
      rd_chk("high", ADR_HS, 32'h0);
      apb(1'b0, 12'h180, 32'h0);
      check("unmapped_err", 32'(errv), 32'h1);
      check("status", 32'(stat), 32'h0);
      $display("test reset done");
      apb(1'b1, ADR_LS, 32'hff);
      apb(1'b1, ADR_HS, 32'hff);
      idle(2);
      check("low_gates", 32'(lsg), 32'h1f);
      check("high_gates", 32'(hsg), 32'h7);
      rd_chk("low", ADR_LS, 32'h1f);
      rd_chk("high", ADR_HS, 32'h0f);
      apb(1'b1, ADR_LS, 32'h0);
      apb(1'b1, ADR_HS, 32'h08);
      idle(2);
      check("low_gates", 32'(lsg), 32'h1);
      check("high_gates", 32'(hsg), 32'h0);
      rd_chk("low", ADR_LS, 32'h1);
      i_hw_watchdog_option <= 1'b1;
      idle(6);
      check("low_gates", 32'(lsg), 32'h5);
      i_hw_watchdog_option <= 1'b0;
      idle(6);
      check("low_gates", 32'(lsg), 32'h1);
      $display("test gates done");
      apb(1'b1, ADR_MODE, 32'h01);
      idle(12);
      check("status", 32'(stat), 32'h04);
      apb(1'b1, ADR_MODE, 32'hfb);
      idle(12);
      rd_chk("mode", ADR_MODE, 32'h83);
      check("status", 32'(stat), 32'h14);
      check("high_gates", 32'(hsg), 32'h0);
      i_pll_lock <= 1'b1;
      idle(12);
      rd_chk("mode", ADR_MODE, 32'h87);
      check("status", 32'(stat), 32'h1c);
      check("high_gates", 32'(hsg), 32'h8);
      $display("test run mode done");
      i_halt_entry <= 1'b1;
      idle(1);
      i_halt_entry <= 1'b0;
      idle(1);
      check("status", 32'(stat), 32'h1d);
      i_halt_wake <= 1'b1;
      idle(1);
      i_halt_wake <= 1'b0;
      idle(1);
      check("status", 32'(stat), 32'h1c);
      rd_chk("mode", ADR_MODE, 32'h07);
      i_halt_entry <= 1'b1;
      idle(1);
      i_halt_entry <= 1'b0;
      idle(1);
      check("status", 32'(stat), 32'h1c);
      $display("test halt done");
      apb(1'b1, ADR_MODE, 32'h02);
      idle(12);
      check("status", 32'(stat), 32'h18);
      apb(1'b1, ADR_MODE, 32'h00);
      idle(12);
      check("status", 32'(stat), 32'h0);
      check("high_gates", 32'(hsg), 32'h0);
      i_nrst <= 1'b0;
      idle(2);
      i_nrst <= 1'b1;
      rd_chk("low", ADR_LS, 32'h0);
      $display("test return and reset done");
      results;
   end
   initial begin
      repeat (5000) @(posedge i_clk);
      num_errors++;
      results;
   end
endmodule
`default_nettype wire
